// ---- hw/exciter_pkg.sv ----
// Shared constants and types of the exciter controller interface
package exciter_pkg;

  // ************************************************************
  // Clock and reference timing
  // ************************************************************
  localparam int SYS_CLOCK_HZ = 100_000_000;
  localparam int REF_CLOCK_HZ = 10_000_000;
  // System cycles per reference period, the reference tick rate
  localparam int REF_TICK_CYCLES = SYS_CLOCK_HZ / REF_CLOCK_HZ;
  localparam int REF_COUNT_W = 4;
  localparam logic [REF_COUNT_W-1:0] REF_COUNT_LAST = REF_COUNT_W'(REF_TICK_CYCLES - 1);
  localparam logic [REF_COUNT_W-1:0] REF_COUNT_RESET = 4'h0;
  // Reference ticks per half period of the converter clock
  localparam int ADC_HALF_TICKS = 4;

  // ************************************************************
  // Data widths and depths
  // ************************************************************
  localparam int SAMPLE_BITS = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int DAC_BITS = 12;
  // Full-scale output of each converter half, millivolts
  localparam int DAC_FULL_SCALE_MV = 2500;

  // ************************************************************
  // Fixed strap levels
  // ************************************************************
  localparam logic FSK_TIED_LEVEL = 1'b0;
  localparam logic CHAN_PICK_C_LEVEL = 1'b1;

  // Positions of the strap inputs in the synchroniser vector
  localparam int STRAP_FSK_A = 0;
  localparam int STRAP_FSK_B = 1;
  localparam int STRAP_CHAN_A = 2;
  localparam int STRAP_CHAN_B = 3;
  localparam int STRAP_MODE = 4;
  localparam int STRAP_RX_FAULT = 5;
  localparam int STRAP_RX_SQUELCH = 6;
  localparam int STRAP_COUNT = 7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    CHANNEL_1 = 3'h1,
    CHANNEL_2 = 3'h2,
    CHANNEL_3 = 3'h3,
    CHANNEL_4 = 3'h4
  } channel_t;

  typedef enum logic {
    MODE_ANALOG = 1'b0,
    MODE_FOUR_LEVEL = 1'b1
  } mode_t;

  typedef enum logic {
    POWER_HALF_FORWARD = 1'b0,
    POWER_HALF_REFLECTED = 1'b1
  } power_half_t;

  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_t;

endpackage : exciter_pkg

// ---- hw/sample_stream_if.sv ----
// Valid/ready sample stream between the interface logic and its FIFO
interface sample_stream_if #(
  parameter int WIDTH = 16
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : sample_stream_if

// ---- hw/sample_fifo.sv ----
// Flip-flop FIFO holding converter samples ahead of the serial link
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic resetn,
  sample_stream_if.sink fill,
  sample_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_index;
  logic [AW-1:0] rd_index;
  logic [CW-1:0] count;
  logic [AW-1:0] next_wr_index;
  logic [AW-1:0] next_rd_index;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // ************************************************************
  // Handshake and pointer arithmetic
  // ************************************************************
  // Full and empty come straight from the occupancy count
  assign fill.ready = (count != CW'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data = store[rd_index];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // Next pointers wrap explicitly so depth need not be a power of two
  always_comb begin
    next_wr_index = wr_index;
    next_rd_index = rd_index;
    next_count = count;
    if (push) begin
      next_wr_index = (wr_index == AW'(DEPTH - 1)) ? '0 : wr_index + 1'b1;
    end
    if (pop) begin
      next_rd_index = (rd_index == AW'(DEPTH - 1)) ? '0 : rd_index + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_index <= '0;
      rd_index <= '0;
      count <= '0;
    end else begin
      wr_index <= next_wr_index;
      rd_index <= next_rd_index;
      count <= next_count;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_index] <= fill.data;
    end
  end
endmodule : sample_fifo

// ---- hw/exciter_controller_interface.sv ----
// Controller-side interface logic of the paging exciter
module exciter_controller_interface
  import exciter_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_BITS,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int DAC_WIDTH = DAC_BITS,
  parameter int ADC_HALF = ADC_HALF_TICKS
) (
  input wire logic clock,
  input wire logic resetn,
  // Straps from the transmitter controller
  input wire logic fsk_symbol_a,
  input wire logic fsk_symbol_b,
  input wire logic chan_pick_a,
  input wire logic chan_pick_b,
  input wire logic mode_pick,
  // Standard receiver status
  input wire logic receiver_fault_in,
  input wire logic receiver_squelch_in,
  // Modulator symbol input, four bits
  output logic [3:0] modulator_symbol,
  output logic fsk_symbol_bit_d,
  output channel_t selected_channel,
  output logic chan_pick_c,
  output mode_t selected_mode,
  output logic receiver_fault,
  output logic receiver_unsquelched,
  // Audio converter side
  output logic adc_clock,
  input wire logic adc_sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] adc_sample_data,
  output logic adc_sample_ready,
  // Synchronous serial link to the modulator
  output logic link_clock,
  output logic link_frame,
  output logic link_data,
  // Power writes from the control processor
  input wire logic power_write,
  input wire logic power_select,
  input wire logic [DAC_WIDTH-1:0] power_code,
  output logic [DAC_WIDTH-1:0] forward_power_level,
  output logic [DAC_WIDTH-1:0] reflected_power_level,
  // Alarm sources and their controller outputs
  input wire logic vswr_detect,
  input wire logic temp_detect,
  input wire logic rf_drive_detect,
  input wire logic carrier_modulated,
  output logic mismatch_alarm,
  output logic temperature_alarm,
  output logic rf_drive_alarm,
  output logic modulation_indication
);
  localparam int BIT_W = $clog2(SAMPLE_WIDTH);
  localparam int ADC_W = $clog2(ADC_HALF + 1);

  // ************************************************************
  // Strap synchroniser
  // ************************************************************
  logic [STRAP_COUNT-1:0] strap_raw;
  logic [STRAP_COUNT-1:0] strap_first;
  logic [STRAP_COUNT-1:0] strap_second;

  assign strap_raw[STRAP_FSK_A] = fsk_symbol_a;
  assign strap_raw[STRAP_FSK_B] = fsk_symbol_b;
  assign strap_raw[STRAP_CHAN_A] = chan_pick_a;
  assign strap_raw[STRAP_CHAN_B] = chan_pick_b;
  assign strap_raw[STRAP_MODE] = mode_pick;
  assign strap_raw[STRAP_RX_FAULT] = receiver_fault_in;
  assign strap_raw[STRAP_RX_SQUELCH] = receiver_squelch_in;

  // Straps may change at any time; only the second stage is decoded
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap_first <= '0;
      strap_second <= '0;
    end else begin
      strap_first <= strap_raw;
      strap_second <= strap_first;
    end
  end

  // ************************************************************
  // Strap decoding
  // ************************************************************
  logic [3:0] next_modulator_symbol;
  channel_t next_channel;
  mode_t next_mode;
  logic next_rx_fault;
  logic next_rx_unsquelched;

  // Open-circuit select bit never depends on the controller
  assign chan_pick_c = CHAN_PICK_C_LEVEL;

  // Decode from the synchronised straps
  always_comb begin
    next_modulator_symbol = {FSK_TIED_LEVEL, FSK_TIED_LEVEL,
                             strap_second[STRAP_FSK_B], strap_second[STRAP_FSK_A]};
    unique case ({strap_second[STRAP_CHAN_B], strap_second[STRAP_CHAN_A]})
      2'b11: next_channel = CHANNEL_1;
      2'b10: next_channel = CHANNEL_2;
      2'b01: next_channel = CHANNEL_3;
      2'b00: next_channel = CHANNEL_4;
    endcase
    next_mode = strap_second[STRAP_MODE] ? MODE_FOUR_LEVEL : MODE_ANALOG;
    next_rx_fault = strap_second[STRAP_RX_FAULT];
    next_rx_unsquelched = strap_second[STRAP_RX_SQUELCH];
  end

  // Decoded straps held in flops
  always_ff @(posedge clock) begin
    if (!resetn) begin
      modulator_symbol <= 4'h0;
      selected_channel <= CHANNEL_4;
      selected_mode <= MODE_ANALOG;
      receiver_fault <= 1'b0;
      receiver_unsquelched <= 1'b0;
    end else begin
      modulator_symbol <= next_modulator_symbol;
      selected_channel <= next_channel;
      selected_mode <= next_mode;
      receiver_fault <= next_rx_fault;
      receiver_unsquelched <= next_rx_unsquelched;
    end
  end

  // Fourth symbol bit, always low in this variant
  assign fsk_symbol_bit_d = modulator_symbol[3];

  // ************************************************************
  // Reference tick and converter clock
  // ************************************************************
  logic [REF_COUNT_W-1:0] ref_count;
  logic [REF_COUNT_W-1:0] next_ref_count;
  logic ref_tick;
  logic [ADC_W-1:0] adc_count;
  logic [ADC_W-1:0] next_adc_count;
  logic next_adc_clock;

  assign ref_tick = (ref_count == REF_COUNT_LAST);

  // Converter clock counts reference ticks, not system cycles
  always_comb begin
    next_ref_count = ref_tick ? REF_COUNT_RESET : ref_count + 1'b1;
    next_adc_count = adc_count;
    next_adc_clock = adc_clock;
    if (ref_tick) begin
      if (adc_count == ADC_W'(ADC_HALF - 1)) begin
        next_adc_count = '0;
        next_adc_clock = !adc_clock;
      end else begin
        next_adc_count = adc_count + 1'b1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ref_count <= REF_COUNT_RESET;
      adc_count <= '0;
      adc_clock <= 1'b0;
    end else begin
      ref_count <= next_ref_count;
      adc_count <= next_adc_count;
      adc_clock <= next_adc_clock;
    end
  end

  // ************************************************************
  // Sample FIFO
  // ************************************************************
  sample_stream_if #(.WIDTH(SAMPLE_WIDTH)) fill_stream ();
  sample_stream_if #(.WIDTH(SAMPLE_WIDTH)) drain_stream ();

  assign fill_stream.valid = adc_sample_valid;
  assign fill_stream.data = adc_sample_data;
  // Converter stalls once the FIFO is full
  assign adc_sample_ready = fill_stream.ready;

  sample_fifo #(
    .WIDTH(SAMPLE_WIDTH),
    .DEPTH(DEPTH)
  ) sample_buffer (
    .clock(clock),
    .resetn(resetn),
    .fill(fill_stream),
    .drain(drain_stream)
  );

  // ************************************************************
  // Serial link to the modulator
  // ************************************************************
  link_state_t link_state;
  link_state_t next_link_state;
  logic [SAMPLE_WIDTH-1:0] shift_word;
  logic [SAMPLE_WIDTH-1:0] next_shift_word;
  logic [BIT_W-1:0] bit_count;
  logic [BIT_W-1:0] next_bit_count;
  logic next_link_clock;
  logic next_link_frame;
  logic link_load;

  // Words leave only in analog mode; in four-level mode the FIFO fills
  assign link_load = (link_state == LINK_IDLE) && ref_tick && (selected_mode == MODE_ANALOG);
  assign drain_stream.ready = link_load;

  // Bits launch on falling link clock, modulator samples on rising
  always_comb begin
    next_link_state = link_state;
    next_shift_word = shift_word;
    next_bit_count = bit_count;
    next_link_clock = link_clock;
    next_link_frame = link_frame;
    unique case (link_state)
      LINK_IDLE: begin
        if (link_load && drain_stream.valid) begin
          next_shift_word = drain_stream.data;
          next_bit_count = '0;
          next_link_clock = 1'b0;
          next_link_frame = 1'b1;
          next_link_state = LINK_SHIFT;
        end
      end
      LINK_SHIFT: begin
        if (ref_tick) begin
          if (!link_clock) begin
            next_link_clock = 1'b1;
          end else if (bit_count == BIT_W'(SAMPLE_WIDTH - 1)) begin
            // Clock rests high between words
            next_link_frame = 1'b0;
            next_link_state = LINK_IDLE;
          end else begin
            next_link_clock = 1'b0;
            next_link_frame = 1'b0;
            next_shift_word = {shift_word[SAMPLE_WIDTH-2:0], 1'b0};
            next_bit_count = bit_count + 1'b1;
          end
        end
      end
    endcase
  end

  // Link registers; data is the word's top bit, sent first
  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_state <= LINK_IDLE;
      shift_word <= '0;
      bit_count <= '0;
      link_clock <= 1'b1;
      link_frame <= 1'b0;
    end else begin
      link_state <= next_link_state;
      shift_word <= next_shift_word;
      bit_count <= next_bit_count;
      link_clock <= next_link_clock;
      link_frame <= next_link_frame;
    end
  end

  assign link_data = shift_word[SAMPLE_WIDTH-1];

  // ************************************************************
  // Dual power converter and alarms
  // ************************************************************
  logic [DAC_WIDTH-1:0] next_forward;
  logic [DAC_WIDTH-1:0] next_reflected;

  // Gating steers each write to one half only; the other holds
  always_comb begin
    next_forward = forward_power_level;
    next_reflected = reflected_power_level;
    if (power_write && (power_select == POWER_HALF_FORWARD)) begin
      next_forward = power_code;
    end
    if (power_write && (power_select == POWER_HALF_REFLECTED)) begin
      next_reflected = power_code;
    end
  end

  // Code is the level; all ones stands for full scale
  always_ff @(posedge clock) begin
    if (!resetn) begin
      forward_power_level <= '0;
      reflected_power_level <= '0;
    end else begin
      forward_power_level <= next_forward;
      reflected_power_level <= next_reflected;
    end
  end

  // Alarm lines registered so the controller sees clean levels
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mismatch_alarm <= 1'b0;
      temperature_alarm <= 1'b0;
      rf_drive_alarm <= 1'b0;
      modulation_indication <= 1'b0;
    end else begin
      mismatch_alarm <= vswr_detect;
      temperature_alarm <= temp_detect;
      rf_drive_alarm <= rf_drive_detect;
      modulation_indication <= carrier_modulated;
    end
  end
endmodule : exciter_controller_interface

// ---- test/exciter_ctl_props.sv ----
// Port-level assertions for the exciter controller interface
module exciter_ctl_checker
  import exciter_pkg::*;
#(
  parameter int DAC_WIDTH = DAC_BITS,
  parameter int ADC_HALF = ADC_HALF_TICKS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic fsk_symbol_a,
  input wire logic fsk_symbol_b,
  input wire logic chan_pick_a,
  input wire logic chan_pick_b,
  input wire logic mode_pick,
  input wire logic [3:0] modulator_symbol,
  input wire logic fsk_symbol_bit_d,
  input wire channel_t selected_channel,
  input wire logic chan_pick_c,
  input wire mode_t selected_mode,
  input wire logic adc_clock,
  input wire logic link_clock,
  input wire logic link_frame,
  input wire logic power_write,
  input wire logic power_select,
  input wire logic [DAC_WIDTH-1:0] power_code,
  input wire logic [DAC_WIDTH-1:0] forward_power_level,
  input wire logic [DAC_WIDTH-1:0] reflected_power_level,
  input wire logic vswr_detect,
  input wire logic temp_detect,
  input wire logic rf_drive_detect,
  input wire logic carrier_modulated,
  input wire logic mismatch_alarm,
  input wire logic temperature_alarm,
  input wire logic rf_drive_alarm,
  input wire logic modulation_indication
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Strap decoding, three cycles behind the pins
  // ************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Cycles from the last of the eight stable checks to the next edge of the converter clock
  localparam int ADC_WAIT = ADC_HALF * REF_TICK_CYCLES - 8;

  a_tied_symbol: assert property (modulator_symbol[3:2] == 2'b00 && !fsk_symbol_bit_d)
    else $error("upper symbol bits not low");
  a_chan_c_open: assert property (chan_pick_c)
    else $error("third channel select not high");
  a_symbol_sync: assert property ($past(resetn, 3) |-> modulator_symbol[1:0] == $past({fsk_symbol_b, fsk_symbol_a}, 3))
    else $error("symbol bits not passed through");
  a_channel_decode: assert property ($past(resetn, 3) |->
    selected_channel == 3'(3'h4 - $past({1'b0, chan_pick_b, chan_pick_a}, 3)))
    else $error("channel decode wrong");
  a_mode_decode: assert property ($past(resetn, 3) |-> selected_mode == $past(mode_pick, 3))
    else $error("mode decode wrong");

  // ************************************************************
  // Alarms, power halves and timing outputs
  // ************************************************************
  a_alarm_follow: assert property ($past(resetn) |-> {mismatch_alarm, temperature_alarm, rf_drive_alarm,
    modulation_indication} == $past({vswr_detect, temp_detect, rf_drive_detect, carrier_modulated}))
    else $error("alarm outputs do not follow detectors");
  a_forward_write: assert property (power_write && power_select == POWER_HALF_FORWARD |=>
    forward_power_level == $past(power_code) && $stable(reflected_power_level))
    else $error("forward write misrouted");
  a_reflect_write: assert property (power_write && power_select == POWER_HALF_REFLECTED |=>
    reflected_power_level == $past(power_code) && $stable(forward_power_level))
    else $error("reflected write misrouted");
  a_power_hold: assert property (!power_write |=> $stable(forward_power_level) && $stable(reflected_power_level))
    else $error("power level changed without a write");
  a_adc_pace: assert property ($changed(adc_clock) |=> $stable(adc_clock)[*8] ##ADC_WAIT $changed(adc_clock))
    else $error("converter clock off pace");
  a_frame_start: assert property ($rose(link_frame) |-> !link_clock ##10 link_clock)
    else $error("word start not low then high clock");
endmodule : exciter_ctl_checker

bind exciter_controller_interface exciter_ctl_checker #(.DAC_WIDTH(DAC_WIDTH), .ADC_HALF(ADC_HALF)) chk (.*);

// ---- test/link_receiver.sv ----
// Modulator-side model that collects words from the serial link
module link_receiver
  import exciter_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clock,
  input wire logic link_frame,
  input wire logic link_data,
  output logic word_valid,
  output logic [SAMPLE_BITS-1:0] word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_seen;
  logic [SAMPLE_BITS-1:0] shift;
  int count;

  // Bits sampled on the rising link clock; frame restarts the count so a lost bit cannot skew later words
  always_ff @(posedge clock) begin
    clock_seen <= link_clock;
    word_valid <= 1'b0;
    if (!resetn) begin
      count <= 0;
    end else if (link_clock && !clock_seen) begin
      shift <= {shift[SAMPLE_BITS-2:0], link_data};
      count <= link_frame ? 1 : count + 1;
      if (!link_frame && count == SAMPLE_BITS - 1) begin
        word_valid <= 1'b1;
        word <= {shift[SAMPLE_BITS-2:0], link_data};
      end
    end
  end
endmodule : link_receiver

// ---- test/exciter_controller_interface_tb_top.sv ----
// Self-checking bench for the exciter controller interface
module exciter_controller_interface_tb_top
  import exciter_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 0, resetn = 0, fsk_symbol_a = 0, fsk_symbol_b = 0, chan_pick_a = 1, chan_pick_b = 1;
  logic mode_pick = 1, receiver_fault_in = 0, receiver_squelch_in = 1, adc_sample_valid = 0;
  logic power_write = 0, power_select = 0, vswr_detect = 0, temp_detect = 0, rf_drive_detect = 0;
  logic carrier_modulated = 0;
  logic [15:0] adc_sample_data = 16'h0;
  logic [11:0] power_code = 12'h0;
  logic [3:0] modulator_symbol;
  logic fsk_symbol_bit_d, chan_pick_c, receiver_fault, receiver_unsquelched, adc_clock, adc_sample_ready;
  logic link_clock, link_frame, link_data, mismatch_alarm, temperature_alarm, rf_drive_alarm;
  logic modulation_indication, rx_valid;
  logic [11:0] forward_power_level, reflected_power_level;
  logic [15:0] rx_word, d;
  logic [31:0] r;
  channel_t selected_channel;
  mode_t selected_mode;
  logic [15:0] expq[$];
  int err_count = 0, tests_run = 0, cycles = 0, n;
  logic adc_seen, adc_armed;
  int adc_span = 0;

  exciter_controller_interface uut (.*);
  link_receiver partner (.clock(clock), .resetn(resetn), .link_clock(link_clock), .link_frame(link_frame),
    .link_data(link_data), .word_valid(rx_valid), .word(rx_word));

  // ************************************************************
  // Clock, hang guard, reporting
  // ************************************************************
  always #5 clock = ~clock;

  // A stuck link would otherwise leave the wait for a free FIFO slot spinning
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      results();
    end
  end

  task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task check_word(input logic [15:0] exp, input logic [15:0] got);
    check_val("link word", exp, got);
  endtask : check_word

  task results;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Converter clock half period; the first edge after reset only arms the count
  always @(posedge clock) begin
    adc_seen <= adc_clock;
    adc_span <= adc_span + 1;
    if (resetn !== 1'b1) begin
      adc_span <= 0;
      adc_armed <= 1'b0;
    end else if (adc_clock !== adc_seen) begin
      if (adc_armed) begin
        check_val("adc half", 16'(ADC_HALF_TICKS * REF_TICK_CYCLES), 16'(adc_span));
      end
      adc_span <= 1;
      adc_armed <= 1'b1;
    end
  end

  // Each received word takes the oldest queued sample
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      if (expq.size() > 0) begin
        check_word(expq.pop_front(), rx_word);
      end else begin
        err_count++;
        $display("FAIL link word expected none seen %h", rx_word);
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    r = $urandom(32'hc3518cb0);
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check_val("fwd reset", 16'h0, {4'h0, forward_power_level});
    // Every select pair twice; other straps and detectors random
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge clock);
      {chan_pick_b, chan_pick_a} <= 2'(i);
      {fsk_symbol_b, fsk_symbol_a} <= r[1:0];
      mode_pick <= r[2];
      {receiver_fault_in, receiver_squelch_in} <= r[4:3];
      {vswr_detect, temp_detect, rf_drive_detect, carrier_modulated} <= r[8:5];
      repeat (4) @(posedge clock);
      #1;
      check_val("symbol", {14'h0, r[1:0]}, {12'h0, modulator_symbol});
      check_val("bit d", 16'h0, {15'h0, fsk_symbol_bit_d});
      check_val("chan c", 16'h1, {15'h0, chan_pick_c});
      check_val("channel", 16'(3'h4 - 3'(i % 4)), 16'(selected_channel));
      check_val("mode", {15'h0, r[2]}, {15'h0, selected_mode});
      check_val("receiver", {14'h0, r[4:3]}, {14'h0, receiver_fault, receiver_unsquelched});
      check_val("alarms", {12'h0, r[8:5]}, {12'h0, mismatch_alarm, temperature_alarm, rf_drive_alarm,
        modulation_indication});
    end
    // Back-to-back writes: a random code to forward, then full scale and zero to reflected
    @(posedge clock);
    power_write <= 1'b1;
    power_code <= r[11:0];
    @(posedge clock);
    power_select <= 1'b1;
    power_code <= 12'hfff;
    @(posedge clock);
    power_code <= 12'h000;
    @(posedge clock);
    power_write <= 1'b0;
    #1;
    check_val("fwd level", {4'h0, r[11:0]}, {4'h0, forward_power_level});
    check_val("refl level", 16'h0, {4'h0, reflected_power_level});
    // Four-level mode holds the link, so the buffer fills until refused
    mode_pick <= 1'b1;
    repeat (4) @(posedge clock);
    n = 0;
    while (n < 64) begin
      d = 16'($urandom);
      adc_sample_data <= d;
      adc_sample_valid <= 1'b1;
      expq.push_back(d);
      @(negedge clock);
      if (adc_sample_ready !== 1'b1) break;
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    check_val("fill count", 16'(FIFO_DEPTH), 16'(n));
    // Analog mode releases the words; the refused sample stays offered until a slot frees
    mode_pick <= 1'b0;
    do @(negedge clock); while (adc_sample_ready !== 1'b1);
    @(posedge clock);
    adc_sample_valid <= 1'b0;
    for (int k = 0; k < 13000 && expq.size() > 0; k++) @(posedge clock);
    check_val("words left", 16'h0, 16'(expq.size()));
    results();
  end
endmodule : exciter_controller_interface_tb_top
